/* zcbu_branch_unit.sv */
// Behaviour
// - Equal-immediate branch redirects when source is zero, else advances by four.
// - Greater-or-equal forms branch when source is at least zero.
// - Greater-than register form branches only when source exceeds zero.
// - Register forms target current address plus whole offset register.
// - Immediate forms target current address plus sign-extended immediate.
// - Delay variants carry the delay flag in instruction bit twenty-five.
// - Delay flag set lets the following instruction complete first.
// - Delay flag clear on a taken branch kills the following sequential instruction.
// - A branch not taken occupies one cycle.
// - A taken delayed branch occupies two cycles.
// - A taken undelayed branch occupies three cycles.
// - A correctly predicted immediate branch occupies one cycle.
// - Immediate misprediction costs three cycles at area setting zero.
// - Immediate misprediction costs eight cycles at area setting two.
// - The sixteen-bit immediate is sign-extended to thirty-two bits.
// - A preceding prefix supplies the upper immediate bits instead.
// - Interrupts and hardware breaks wait until the delay slot completes.
`timescale 1ns/100ps
`default_nettype none
`include "zcbu_map.svh"

module zcbu_branch_unit (
	// Clock and reset.
	input  wire logic              i_ref_clk,
	input  wire logic              i_arst_n,
	// Instruction issue.
	input  wire logic              i_instr_vld,
	input  wire logic [31:0]       i_instr,
	input  wire logic [31:0]       i_pc,
	output logic                   o_ready,
	output logic                   o_claim,
	// Register file operands.
	output logic [4:0]             o_src_idx,
	output logic [4:0]             o_off_idx,
	input  wire logic [31:0]       i_src_val,
	input  wire logic [31:0]       i_off_val,
	// Immediate prefix from the previous instruction.
	input  wire logic              i_prefix_vld,
	input  wire logic [15:0]       i_prefix,
	// Branch prediction and core configuration.
	input  wire logic              i_pred_vld,
	input  wire logic              i_pred_taken,
	input  wire zcbu_pkg::zcbu_area_t i_area_optimisation_setting,
	// Branch resolution.
	output logic                   o_resolve,
	output logic                   o_taken,
	output logic                   o_kill_next,
	output logic [31:0]            o_next_pc,
	// Delay slot and interrupt gating.
	input  wire logic              i_slot_done,
	input  wire logic              i_irq_req,
	input  wire logic              i_brk_req,
	output logic                   o_irq_hold,
	output logic                   o_irq_grant,
	output logic                   o_brk_grant
);
	import zcbu_pkg::*;

	// Decode bundle, registered state and the helper terms of the issue decision.
	zcbu_dec_if  dif ();
	zcbu_state_t state_reg;
	zcbu_state_t state_next;
	logic [1:0]  rst_sync_reg;
	logic        rst_n;
	logic        accept;
	logic        predicted;
	logic        pred_hit;
	logic [3:0]  cost;
	logic        stall_last;

	// Reset is released through two flops so every flop leaves reset on one edge.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Operands into the shared decode bundle.
	assign dif.instr      = i_instr;
	assign dif.src_val    = i_src_val;
	assign dif.pc         = i_pc;
	assign dif.off_val    = i_off_val;
	assign dif.prefix_vld = i_prefix_vld;
	assign dif.prefix     = i_prefix;

	// Field split and condition test against zero.
	zcbu_decode u_decode (
		.dif (dif)
	);

	// Target and fall-through addresses.
	zcbu_target u_target (
		.tif (dif)
	);

	// The unit claims only the words that decode as its own branch forms; any other
	// word passes by, so the issue stage must find its owner elsewhere.
	assign o_claim   = i_instr_vld && dif.is_branch;
	// Register indices leave straight away, since the operands must come back in the
	// same cycle; a registered index would cost every branch one more cycle.
	assign o_src_idx = dif.src_idx;
	assign o_off_idx = dif.off_idx;

	// A new branch is taken only while no earlier branch still occupies the unit.
	assign o_ready = (state_reg.fsm == ZCBU_IDLE);
	assign accept  = o_claim && o_ready;

	// Prediction applies to the immediate forms only; register forms always resolve late.
	assign predicted = i_pred_vld && dif.is_imm;
	assign pred_hit  = (i_pred_taken == dif.cond_met);

	// The stall counter holds the cycles still to wait after the taking edge.
	// It is loaded with the cost less one, so a one-cycle branch never stalls and
	// the issue stage may offer the next word at once.
	// Last cycle of a stall, when the unit opens again at the next edge.
	assign stall_last = (state_reg.cnt == 4'h1);

	// Cycle cost of the branch on offer, counted from the edge that takes it.
	// Area setting one has no cost of its own, so it shares the fast recovery; a user
	// who picks it must not rely on that figure.
	always_comb begin
		if (predicted && pred_hit) begin
			cost = `ZCBU_COST_HIT;
		end else if (predicted && (i_area_optimisation_setting == `ZCBU_AREA_SMALL)) begin
			cost = `ZCBU_COST_MISS_AREA;
		end else if (predicted) begin
			cost = `ZCBU_COST_MISS_FAST;
		end else if (!dif.cond_met) begin
			cost = `ZCBU_COST_FALL;
		end else if (dif.delay) begin
			cost = `ZCBU_COST_DELAY;
		end else begin
			cost = `ZCBU_COST_NODELAY;
		end
	end

	// Next state: outcome capture, stall count and interrupt hold.
	// When a new delayed branch arrives just as the hold would clear, the set wins.
	always_comb begin
		state_next         = state_reg;
		state_next.resolve = 1'b0;
		unique case (state_reg.fsm)
			ZCBU_IDLE: begin
				if (accept) begin
					state_next.resolve   = 1'b1;
					state_next.taken     = dif.cond_met;
					// A delay slot is never killed.
					state_next.kill_next = dif.cond_met && !dif.delay;
					state_next.next_pc   = dif.cond_met ? dif.target : dif.seq_pc;
					if (cost > `ZCBU_COST_FALL) begin
						state_next.fsm = ZCBU_STALL;
						state_next.cnt = 4'(cost - 4'h1);
					end
				end
			end
			ZCBU_STALL: begin
				if (stall_last) begin
					state_next.fsm = ZCBU_IDLE;
					state_next.cnt = `ZCBU_CNT_RST;
				end else begin
					state_next.cnt = 4'(state_reg.cnt - 4'h1);
				end
			end
		endcase
		if (accept && dif.delay) begin
			state_next.hold = 1'b1;
		end else if (state_reg.hold && i_slot_done && o_ready) begin
			state_next.hold = 1'b0;
		end
	end

	// State register; the synchronised reset clears it.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.fsm       <= ZCBU_IDLE;
			state_reg.cnt       <= `ZCBU_CNT_RST;
			state_reg.resolve   <= 1'b0;
			state_reg.taken     <= 1'b0;
			state_reg.kill_next <= 1'b0;
			state_reg.next_pc   <= `ZCBU_PC_RST;
			state_reg.hold      <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outcome of the last branch; taken, kill and address stand until the next one resolves, while o_resolve pulses for one cycle.
	assign o_resolve   = state_reg.resolve;
	assign o_taken     = state_reg.taken;
	assign o_kill_next = state_reg.kill_next;
	assign o_next_pc   = state_reg.next_pc;

	// Interrupt and break grants are plain gates on the hold.
	// A request is not stored here, so the requester must keep it up until granted.
	assign o_irq_hold  = state_reg.hold;
	assign o_irq_grant = i_irq_req && !state_reg.hold;
	assign o_brk_grant = i_brk_req && !state_reg.hold;

	// The checks below sample at the rising edge and stay quiet while the
	// synchronised reset holds the unit.

	a_eq_cond: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && (i_instr[`ZCBU_COND_MSB:`ZCBU_COND_LSB] == `ZCBU_COND_EQ) |=>
		o_taken == ($past(i_src_val) == 32'h0000_0000))
		else $error("Equal-to-zero branch decision is wrong.");

	a_fall_target: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && !dif.cond_met |=>
		!o_taken && (o_next_pc == 32'($past(i_pc) + `ZCBU_SEQ_STEP)))
		else $error("Fall-through address is wrong.");

	a_ge_cond: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && (i_instr[`ZCBU_COND_MSB:`ZCBU_COND_LSB] == `ZCBU_COND_GE) |=>
		o_taken == !$past(i_src_val[31]))
		else $error("Greater-or-equal branch decision is wrong.");

	a_gt_cond: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && (i_instr[`ZCBU_COND_MSB:`ZCBU_COND_LSB] == `ZCBU_COND_GT) |=>
		o_taken == (($past(i_src_val) != 32'h0000_0000) && !$past(i_src_val[31])))
		else $error("Greater-than branch decision is wrong.");

	a_reg_target: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.cond_met && !dif.is_imm |=>
		o_next_pc == 32'($past(i_pc) + $past(i_off_val)))
		else $error("Register-form branch target is wrong.");

	a_imm_target: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.cond_met && dif.is_imm && !i_prefix_vld |=>
		o_next_pc == 32'($past(i_pc) + {{16{$past(dif.imm16[15])}}, $past(dif.imm16)}))
		else $error("Immediate-form branch target is wrong.");

	a_prefix_target: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.cond_met && dif.is_imm && i_prefix_vld |=>
		o_next_pc == 32'($past(i_pc) + {$past(i_prefix), $past(dif.imm16)}))
		else $error("Prefixed branch target is wrong.");

	a_kill_next: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept |=>
		o_kill_next == ($past(dif.cond_met) && !$past(dif.delay)))
		else $error("Sequential kill is wrong.");

	a_slot_kept: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.delay |=>
		!o_kill_next)
		else $error("Delay slot was killed.");

	a_resolve_pulse: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept |=>
		o_resolve)
		else $error("Accepted branch did not resolve.");

	a_fall_cost: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && !predicted && !dif.cond_met |=>
		o_ready)
		else $error("Fall-through branch took more than one cycle.");

	a_delay_cost: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && !predicted && dif.cond_met && dif.delay |=>
		!o_ready ##1 o_ready)
		else $error("Delayed taken branch cost is wrong.");

	a_nodelay_cost: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && !predicted && dif.cond_met && !dif.delay |=>
		!o_ready [*2] ##1 o_ready)
		else $error("Undelayed taken branch cost is wrong.");

	a_hit_cost: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && predicted && pred_hit |=>
		o_ready)
		else $error("Correctly predicted branch cost is wrong.");

	a_miss_fast: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && predicted && !pred_hit && (i_area_optimisation_setting == `ZCBU_AREA_FAST)
		|=> !o_ready [*2] ##1 o_ready)
		else $error("Fast misprediction cost is wrong.");

	a_miss_area: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && predicted && !pred_hit && (i_area_optimisation_setting == `ZCBU_AREA_SMALL)
		|=> !o_ready [*6] ##[1:3] o_ready)
		else $error("Slow misprediction cost is wrong.");

	// Hold raised by a delayed branch.
	a_hold_set: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.delay |=>
		o_irq_hold)
		else $error("Delayed branch did not hold interrupts.");

	a_grant_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		o_irq_hold |->
		!o_irq_grant && !o_brk_grant)
		else $error("Grant given while the delay slot is open.");

	// Reserved bits refuse a register form.
	a_claim_rsv: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
		i_instr_vld && (i_instr[`ZCBU_RSV_MSB:0] != 11'h000)
		&& (i_instr[`ZCBU_OPC_MSB:`ZCBU_OPC_LSB] == `ZCBU_OPC_REG) |-> !o_claim)
		else $error("Register form with reserved bits was claimed.");

	// Main scenarios that the bench should reach.
	// A taken delayed branch.
	c_taken_delay: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.cond_met && dif.delay);
	// A misprediction at the small area setting.
	c_miss_area: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && predicted && !pred_hit && (i_area_optimisation_setting == `ZCBU_AREA_SMALL));
	// A prefixed immediate branch.
	c_prefix_branch: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
		accept && dif.is_imm && i_prefix_vld);
	// An interrupt deferred by an open delay slot.
	c_irq_deferred: cover property (@(posedge i_ref_clk) disable iff (!rst_n)
		o_irq_hold && i_irq_req);

endmodule : zcbu_branch_unit

`default_nettype wire

/* zcbu_map.svh */
`ifndef ZCBU_MAP_SVH
`define ZCBU_MAP_SVH

// Instruction word fields, bit 31 is the first bit of the opcode.
`define ZCBU_OPC_MSB        31
`define ZCBU_OPC_LSB        26
`define ZCBU_DELAY_BIT      25
`define ZCBU_COND_MSB       24
`define ZCBU_COND_LSB       21
`define ZCBU_SRC_MSB        20
`define ZCBU_SRC_LSB        16
`define ZCBU_OFF_MSB        15
`define ZCBU_OFF_LSB        11
`define ZCBU_IMM_MSB        15
`define ZCBU_RSV_MSB        10

// Opcode and condition encodings of the handled branch forms.
`define ZCBU_OPC_REG        6'h27
`define ZCBU_OPC_IMM        6'h2f
`define ZCBU_COND_EQ        4'h0
`define ZCBU_COND_GT        4'h4
`define ZCBU_COND_GE        4'h5

// Sequential step and cycle costs of one branch.
`define ZCBU_SEQ_STEP       32'h0000_0004
`define ZCBU_COST_FALL      4'h1
`define ZCBU_COST_HIT       4'h1
`define ZCBU_COST_DELAY     4'h2
`define ZCBU_COST_NODELAY   4'h3
`define ZCBU_COST_MISS_FAST 4'h3
`define ZCBU_COST_MISS_AREA 4'h8
`define ZCBU_AREA_SMALL     2'h2
`define ZCBU_AREA_FAST      2'h0

// Reset values of the unit's state.
`define ZCBU_CNT_RST        4'h0
`define ZCBU_PC_RST         32'h0000_0000

`endif

/* zcbu_pkg.sv */
package zcbu_pkg;

	// Area optimisation setting of the core.
	typedef logic [1:0] zcbu_area_t;

	// Occupancy states of the branch unit.
	typedef enum logic [0:0] {
		ZCBU_IDLE,
		ZCBU_STALL
	} zcbu_fsm_t;

	// Whole state of the top module.
	typedef struct packed {
		zcbu_fsm_t   fsm;
		logic [3:0]  cnt;
		logic        resolve;
		logic        taken;
		logic        kill_next;
		logic [31:0] next_pc;
		logic        hold;
	} zcbu_state_t;

endpackage : zcbu_pkg

/* zcbu_dec_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Decoded branch fields passed between the top module and its helpers.
interface zcbu_dec_if;
	logic [31:0] instr;
	logic [31:0] src_val;
	logic [31:0] pc;
	logic [31:0] off_val;
	logic        prefix_vld;
	logic [15:0] prefix;
	logic        is_branch;
	logic        is_imm;
	logic        delay;
	logic        cond_met;
	logic [4:0]  src_idx;
	logic [4:0]  off_idx;
	logic [15:0] imm16;
	logic [31:0] target;
	logic [31:0] seq_pc;

	modport dec (input instr, src_val,
		output is_branch, is_imm, delay, cond_met, src_idx, off_idx, imm16);
	modport tgt (input pc, off_val, prefix_vld, prefix, is_imm, imm16,
		output target, seq_pc);
	modport core (output instr, src_val, pc, off_val, prefix_vld, prefix,
		input is_branch, is_imm, delay, cond_met, src_idx, off_idx, imm16, target, seq_pc);
endinterface : zcbu_dec_if

`default_nettype wire

/* zcbu_decode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "zcbu_map.svh"

module zcbu_decode (
	// Decoded fields.
	zcbu_dec_if.dec dif
);
	import zcbu_pkg::*;

	logic [5:0] opc;
	logic [3:0] cond;
	logic       reg_form;
	logic       imm_form;

	// Field split and condition test against zero.
	always_comb begin
		opc      = dif.instr[`ZCBU_OPC_MSB:`ZCBU_OPC_LSB];
		cond     = dif.instr[`ZCBU_COND_MSB:`ZCBU_COND_LSB];
		// Reserved low bits of register forms.
		reg_form = (opc == `ZCBU_OPC_REG) && (dif.instr[`ZCBU_RSV_MSB:0] == 11'h000)
			&& ((cond == `ZCBU_COND_GE) || (cond == `ZCBU_COND_GT));
		imm_form = (opc == `ZCBU_OPC_IMM)
			&& ((cond == `ZCBU_COND_EQ) || (cond == `ZCBU_COND_GE));
		dif.is_branch = reg_form || imm_form;
		dif.is_imm    = imm_form;
		dif.delay     = dif.instr[`ZCBU_DELAY_BIT];
		dif.src_idx   = dif.instr[`ZCBU_SRC_MSB:`ZCBU_SRC_LSB];
		dif.off_idx   = dif.instr[`ZCBU_OFF_MSB:`ZCBU_OFF_LSB];
		dif.imm16     = dif.instr[`ZCBU_IMM_MSB:0];
		unique case (cond)
			`ZCBU_COND_EQ: dif.cond_met = (dif.src_val == 32'h0000_0000);
			`ZCBU_COND_GT: dif.cond_met = !dif.src_val[31] && (dif.src_val != 32'h0000_0000);
			`ZCBU_COND_GE: dif.cond_met = !dif.src_val[31];
			default:       dif.cond_met = 1'b0;
		endcase
	end

endmodule : zcbu_decode

`default_nettype wire

/* zcbu_target.sv */
`timescale 1ns/100ps
`default_nettype none
`include "zcbu_map.svh"

module zcbu_target (
	// Target and fall-through addresses.
	zcbu_dec_if.tgt tif
);
	import zcbu_pkg::*;

	logic [31:0] offset;

	// Offset selection; a prefix replaces the sign extension entirely.
	always_comb begin
		if (tif.is_imm && tif.prefix_vld) begin
			offset = {tif.prefix, tif.imm16};
		end else if (tif.is_imm) begin
			offset = {{16{tif.imm16[15]}}, tif.imm16};
		end else begin
			offset = tif.off_val;
		end
		tif.target = 32'(tif.pc + offset);
		tif.seq_pc = 32'(tif.pc + `ZCBU_SEQ_STEP);
	end

endmodule : zcbu_target

`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "zcbu_map.svh"

module tb;
	import zcbu_pkg::*;
	logic        clk, rst_n, vld, pv, pdv, pdt, sd, irq;
	logic [31:0] ins, pc, s, o;
	logic [15:0] pf;
	zcbu_area_t  ar;
	logic        rdy, res, tk, kill, ig, clm, ih, bg, brk;
	logic [4:0]  sidx, oidx;
	logic [31:0] npc;
	int          err_total, comparisons;
	int          cyc = 0;

	zcbu_branch_unit DUT (.i_ref_clk(clk), .i_arst_n(rst_n), .i_instr_vld(vld), .i_instr(ins),
		.i_pc(pc), .o_ready(rdy), .o_claim(clm), .o_src_idx(sidx), .o_off_idx(oidx),
		.i_src_val(s), .i_off_val(o), .i_prefix_vld(pv), .i_prefix(pf), .i_pred_vld(pdv),
		.i_pred_taken(pdt), .i_area_optimisation_setting(ar), .o_resolve(res), .o_taken(tk),
		.o_kill_next(kill), .o_next_pc(npc), .i_slot_done(sd), .i_irq_req(irq),
		.i_brk_req(brk), .o_irq_hold(ih), .o_irq_grant(ig), .o_brk_grant(bg));

	// Free-running core clock, 8 ns period.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycle ceiling so a stuck handshake cannot hang the run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One branch: issue, wait for resolution, judge outcome, address and cost.
	task automatic br(input logic [31:0] i, sv, ov, input logic p, input logic [15:0] px,
		input logic qv, qt, input zcbu_area_t a, input logic et, input logic [31:0] epc,
		input int lo, input int hi);
		int c;
		@(negedge clk);
		vld = 1'b1; ins = i; s = sv; o = ov; pv = p; pf = px; pdv = qv; pdt = qt; ar = a;
		#1;
		chk(clm, 1'b1);
		chk(sidx, i[`ZCBU_SRC_MSB:`ZCBU_SRC_LSB]);
		chk(oidx, i[`ZCBU_OFF_MSB:`ZCBU_OFF_LSB]);
		c = 0;
		while (rdy !== 1'b1 && c < 50) begin
			@(negedge clk);
			c++;
		end
		// Taken at the next rising edge; the resolution pulse stands one cycle.
		@(negedge clk);
		vld = 1'b0;
		pv = 1'b0;
		c = 1;
		chk(res, 1'b1);
		chk(tk, et);
		chk(npc, epc);
		chk(kill, et & ~i[`ZCBU_DELAY_BIT]);
		while (rdy !== 1'b1 && c < 20) begin
			@(negedge clk);
			c++;
		end
		chk(c >= lo && c <= hi, 1'b1);
	endtask : br

	// Delay-slot filler or stray word: never a branch, so the unit must not claim it.
	// Slot holds no branch.
	task automatic slot(input logic [31:0] w);
		@(negedge clk);
		vld = 1'b1;
		ins = w;
		#1;
		chk(clm, 1'b0);
		@(negedge clk);
		vld = 1'b0;
		chk(res, 1'b0);
	endtask : slot

	function automatic logic [31:0] rf(input logic [3:0] cd, input logic d, input logic [4:0] r);
		return {`ZCBU_OPC_REG, d, cd, r, 5'h02, 11'h000};
	endfunction : rf

	function automatic logic [31:0] im(input logic [3:0] cd, input logic d, input logic [15:0] v);
		return {`ZCBU_OPC_IMM, d, cd, 5'h03, v};
	endfunction : im

	task automatic wrap_up();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// Reset held four cycles, then the branch forms one after another.
	initial begin
		rst_n = 1'b0; vld = 1'b0; ins = 32'h0; pc = 32'h100; s = 32'h0; o = 32'h0;
		pv = 1'b0; pf = 16'h0; pdv = 1'b0; pdt = 1'b0; ar = 2'h0; sd = 1'b1; irq = 1'b0;
		err_total = 0; comparisons = 0; brk = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		br(im(4'h0, 0, 16'h0010), 0, 0, 0, 0, 0, 0, 0, 1, 32'h110, 3, 3);
		br(im(4'h0, 0, 16'h0010), 1, 0, 0, 0, 0, 0, 0, 0, 32'h104, 1, 1);
		br(im(4'h5, 1, 16'hfff8), 0, 0, 0, 0, 0, 0, 0, 1, 32'h0f8, 2, 2);
		slot(32'h0000_0000);
		br(rf(4'h5, 0, 5'h01), 32'hffffffff, 4, 0, 0, 0, 0, 0, 0, 32'h104, 1, 1);
		br(rf(4'h5, 0, 5'h01), 32'h7fffffff, 32'h80000000, 0, 0, 0, 0, 0, 1,
			32'h80000100, 3, 3);
		br(rf(4'h4, 0, 5'h01), 0, 32'h20, 0, 0, 0, 0, 0, 0, 32'h104, 1, 1);
		br(rf(4'h4, 1, 5'h01), 1, 32'h20, 0, 0, 0, 0, 0, 1, 32'h120, 2, 2);
		slot(rf(4'h5, 0, 5'h01) | 32'h0000_0001);
		br(im(4'h0, 0, 16'hfff0), 0, 0, 1, 16'h0001, 0, 0, 0, 1, 32'h200f0, 3, 3);
		br(im(4'h5, 0, 16'h0040), 5, 0, 0, 0, 1, 1, 0, 1, 32'h140, 1, 1);
		br(im(4'h5, 0, 16'h0040), 5, 0, 0, 0, 1, 0, 0, 1, 32'h140, 3, 3);
		br(im(4'h5, 0, 16'h0040), 5, 0, 0, 0, 1, 0, 2'h2, 1, 32'h140, 7, 9);
		// Interrupt and break must wait while the delay slot is still open.
		sd = 1'b0;
		br(im(4'h5, 1, 16'h0008), 0, 0, 0, 0, 0, 0, 0, 1, 32'h108, 2, 2);
		irq = 1'b1;
		brk = 1'b1;
		repeat (3) @(negedge clk);
		chk(ih, 1'b1);
		chk(ig, 1'b0);
		chk(bg, 1'b0);
		sd = 1'b1;
		repeat (2) @(negedge clk);
		chk(ih, 1'b0);
		chk(ig, 1'b1);
		chk(bg, 1'b1);
		irq = 1'b0;
		brk = 1'b0;
		wrap_up();
	end
endmodule : tb

`default_nettype wire
